//--- verilog/cra_fixed_auth.sv
// Behaviour
// - every reply carries the seed behind the session key with the fixed challenge
// - wide seed is high half over low half, each 64 bits
// - every random word is handed out only once; only a repeat of the last word taken is refused
// - on request reuse the stored key and seed or derive a new pair
// - derivation seed used once and never equal to a portable-side seed
// - stored key and seed kept until next derivation, reusable many times
// - each authentication takes a fixed challenge that differs from the one handed out before it
// - response computed from fixed challenge, portable challenge and session key
// - reply holds response, fixed challenge and seed used
// - an assigned pair is always used and its seed always sent back
// - key reuse or forced derivation per authentication is selectable
// - fixed-side and portable-side session keys never share a seed (checked only for a newly derived seed, not for assigned or reused pairs)
// - fixed and portable challenges are 64 bits wide
// - a new random fixed challenge for every fixed-side authentication
`timescale 1ns/10ps
`default_nettype none
module cra_fixed_auth
    import cra_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    // request from the portable termination
    input  wire logic              req_valid_in,
    input  wire logic [CHAL_W-1:0] portable_challenge_in,
    // profile and roaming pair
    input  wire logic              reuse_allowed_in,
    input  wire logic              assigned_valid_in,
    input  wire logic [SEED_W-1:0] assigned_seed_in,
    input  wire logic [KEY_W-1:0]  assigned_key_in,
    input  wire logic [SEED_W-1:0] portable_seed_in,
    // random sources
    input  wire logic [HALF_W-1:0] seed_low_rand_in,
    input  wire logic              seed_low_rand_valid_in,
    input  wire logic [HALF_W-1:0] seed_high_rand_in,
    input  wire logic              seed_high_rand_valid_in,
    input  wire logic [CHAL_W-1:0] chal_rand_in,
    input  wire logic              chal_rand_valid_in,
    // fixed side key derivation unit
    output logic                   kd_start_out,
    output logic      [SEED_W-1:0] kd_seed_out,
    input  wire logic              kd_done_in,
    input  wire logic [KEY_W-1:0]  kd_key_in,
    // fixed response process unit
    output logic                   rp_start_out,
    output logic      [CHAL_W-1:0] rp_fixed_challenge_out,
    output logic      [CHAL_W-1:0] rp_portable_challenge_out,
    output logic      [KEY_W-1:0]  rp_key_out,
    input  wire logic              rp_done_in,
    input  wire logic [RESP_W-1:0] rp_response_in,
    // reply to the portable termination
    output logic                   reply_valid_out,
    output logic      [RESP_W-1:0] reply_response_out,
    output logic      [CHAL_W-1:0] reply_fixed_challenge_out,
    output logic      [SEED_W-1:0] reply_seed_out,
    // response check
    input  wire logic              check_valid_in,
    input  wire logic [RESP_W-1:0] check_response_in,
    output logic                   check_done_out,
    output logic                   check_pass_out,
    // status
    output logic                   busy_out,
    output logic                   stored_valid_out
);
    cra_state_t        state_reg;
    cra_state_t        state_next;
    logic [CHAL_W-1:0] pchal_reg;
    logic [CHAL_W-1:0] pchal_next;
    logic [SEED_W-1:0] seed_used_reg;
    logic [SEED_W-1:0] seed_used_next;
    logic [KEY_W-1:0]  key_used_reg;
    logic [KEY_W-1:0]  key_used_next;
    logic [SEED_W-1:0] stored_seed_reg;
    logic [SEED_W-1:0] stored_seed_next;
    logic [KEY_W-1:0]  stored_key_reg;
    logic [KEY_W-1:0]  stored_key_next;
    logic              stored_valid_reg;
    logic              stored_valid_next;
    logic              kd_start_reg;
    logic              kd_start_next;
    logic [SEED_W-1:0] kd_seed_reg;
    logic [SEED_W-1:0] kd_seed_next;
    logic              rp_start_reg;
    logic              rp_start_next;
    logic [CHAL_W-1:0] rp_fc_reg;
    logic [CHAL_W-1:0] rp_fc_next;
    logic [CHAL_W-1:0] rp_pc_reg;
    logic [CHAL_W-1:0] rp_pc_next;
    logic [KEY_W-1:0]  rp_key_reg;
    logic [KEY_W-1:0]  rp_key_next;
    logic              reply_valid_reg;
    logic              reply_valid_next;
    logic [RESP_W-1:0] reply_resp_reg;
    logic [RESP_W-1:0] reply_resp_next;
    logic [CHAL_W-1:0] reply_fc_reg;
    logic [CHAL_W-1:0] reply_fc_next;
    logic [SEED_W-1:0] reply_seed_reg;
    logic [SEED_W-1:0] reply_seed_next;
    logic [RESP_W-1:0] resp_store_reg;
    logic [RESP_W-1:0] resp_store_next;
    logic              busy_reg;
    logic              busy_next;

    logic [HALF_W-1:0] fresh_rand  [NUM_FRESH];
    logic              fresh_rv    [NUM_FRESH];
    logic [HALF_W-1:0] fresh_word  [NUM_FRESH];
    logic              fresh_ready [NUM_FRESH];
    logic              fresh_take  [NUM_FRESH];
    logic [SEED_W-1:0] seed_cand;

    assign fresh_rand[IDX_LOW]  = seed_low_rand_in;
    assign fresh_rv[IDX_LOW]    = seed_low_rand_valid_in;
    assign fresh_rand[IDX_HIGH] = seed_high_rand_in;
    assign fresh_rv[IDX_HIGH]   = seed_high_rand_valid_in;
    assign fresh_rand[IDX_CHAL] = chal_rand_in;
    assign fresh_rv[IDX_CHAL]   = chal_rand_valid_in;

    // one single-use source per seed half and for the fixed challenge
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FRESH; gi++) begin : g_fresh
            cra_fresh_word u_fresh (
                .ref_clk_in    (ref_clk_in),
                .rst_n_in      (rst_n_in),
                .rand_word_in  (fresh_rand[gi]),
                .rand_valid_in (fresh_rv[gi]),
                .take_in       (fresh_take[gi]),
                .word_out      (fresh_word[gi]),
                .ready_out     (fresh_ready[gi])
            );
        end
    endgenerate

    assign seed_cand = {fresh_word[IDX_HIGH], fresh_word[IDX_LOW]};

    always_comb begin
        state_next        = state_reg;
        pchal_next        = pchal_reg;
        seed_used_next    = seed_used_reg;
        key_used_next     = key_used_reg;
        stored_seed_next  = stored_seed_reg;
        stored_key_next   = stored_key_reg;
        stored_valid_next = stored_valid_reg;
        kd_start_next     = 1'b0;
        kd_seed_next      = kd_seed_reg;
        rp_start_next     = 1'b0;
        rp_fc_next        = rp_fc_reg;
        rp_pc_next        = rp_pc_reg;
        rp_key_next       = rp_key_reg;
        reply_valid_next  = 1'b0;
        reply_resp_next   = reply_resp_reg;
        reply_fc_next     = reply_fc_reg;
        reply_seed_next   = reply_seed_reg;
        resp_store_next   = resp_store_reg;
        for (int i = 0; i < NUM_FRESH; i++) begin
            fresh_take[i] = 1'b0;
        end
        unique case (state_reg)
            // requests while busy are ignored; the terminal retries
            ST_IDLE: begin
                if (req_valid_in) begin
                    pchal_next = portable_challenge_in;
                    if (assigned_valid_in) begin
                        seed_used_next = assigned_seed_in;
                        key_used_next  = assigned_key_in;
                        state_next     = ST_CHAL;
                    end else if (reuse_allowed_in && stored_valid_reg) begin
                        seed_used_next = stored_seed_reg;
                        key_used_next  = stored_key_reg;
                        state_next     = ST_CHAL;
                    end else begin
                        state_next = ST_SEED;
                    end
                end
            end
            ST_SEED: begin
                if (fresh_ready[IDX_LOW] && fresh_ready[IDX_HIGH]) begin
                    // both halves are burnt even when refused, so none is ever retried
                    fresh_take[IDX_LOW]  = 1'b1;
                    fresh_take[IDX_HIGH] = 1'b1;
                    if (seed_cand != portable_seed_in) begin
                        kd_start_next = 1'b1;
                        kd_seed_next  = seed_cand;
                        state_next    = ST_DERIVE;
                    end
                end
            end
            ST_DERIVE: begin
                if (kd_done_in) begin
                    stored_seed_next  = kd_seed_reg;
                    stored_key_next   = kd_key_in;
                    stored_valid_next = 1'b1;
                    seed_used_next    = kd_seed_reg;
                    key_used_next     = kd_key_in;
                    state_next        = ST_CHAL;
                end
            end
            ST_CHAL: begin
                if (fresh_ready[IDX_CHAL]) begin
                    fresh_take[IDX_CHAL] = 1'b1;
                    rp_start_next = 1'b1;
                    rp_fc_next    = fresh_word[IDX_CHAL];
                    rp_pc_next    = pchal_reg;
                    rp_key_next   = key_used_reg;
                    state_next    = ST_RESP;
                end
            end
            ST_RESP: begin
                if (rp_done_in) begin
                    reply_valid_next = 1'b1;
                    reply_resp_next  = rp_response_in;
                    reply_fc_next    = rp_fc_reg;
                    reply_seed_next  = seed_used_reg;
                    resp_store_next  = rp_response_in;
                    state_next       = ST_IDLE;
                end
            end
        endcase
        busy_next = (state_next != ST_IDLE);
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state_reg        <= ST_IDLE;
            pchal_reg        <= HALF_RST;
            seed_used_reg    <= SEED_RST;
            key_used_reg     <= KEY_RST;
            stored_seed_reg  <= SEED_RST;
            stored_key_reg   <= KEY_RST;
            stored_valid_reg <= 1'b0;
            kd_start_reg     <= 1'b0;
            kd_seed_reg      <= SEED_RST;
            rp_start_reg     <= 1'b0;
            rp_fc_reg        <= HALF_RST;
            rp_pc_reg        <= HALF_RST;
            rp_key_reg       <= KEY_RST;
            reply_valid_reg  <= 1'b0;
            reply_resp_reg   <= RESP_RST;
            reply_fc_reg     <= HALF_RST;
            reply_seed_reg   <= SEED_RST;
            resp_store_reg   <= RESP_RST;
            busy_reg         <= 1'b0;
        end else begin
            state_reg        <= state_next;
            pchal_reg        <= pchal_next;
            seed_used_reg    <= seed_used_next;
            key_used_reg     <= key_used_next;
            stored_seed_reg  <= stored_seed_next;
            stored_key_reg   <= stored_key_next;
            stored_valid_reg <= stored_valid_next;
            kd_start_reg     <= kd_start_next;
            kd_seed_reg      <= kd_seed_next;
            rp_start_reg     <= rp_start_next;
            rp_fc_reg        <= rp_fc_next;
            rp_pc_reg        <= rp_pc_next;
            rp_key_reg       <= rp_key_next;
            reply_valid_reg  <= reply_valid_next;
            reply_resp_reg   <= reply_resp_next;
            reply_fc_reg     <= reply_fc_next;
            reply_seed_reg   <= reply_seed_next;
            resp_store_reg   <= resp_store_next;
            busy_reg         <= busy_next;
        end
    end

    cra_resp_cmp u_cmp (
        .ref_clk_in     (ref_clk_in),
        .rst_n_in       (rst_n_in),
        .check_valid_in (check_valid_in),
        .expected_in    (resp_store_reg),
        .received_in    (check_response_in),
        .done_out       (check_done_out),
        .pass_out       (check_pass_out)
    );

    assign kd_start_out              = kd_start_reg;
    assign kd_seed_out               = kd_seed_reg;
    assign rp_start_out              = rp_start_reg;
    assign rp_fixed_challenge_out    = rp_fc_reg;
    assign rp_portable_challenge_out = rp_pc_reg;
    assign rp_key_out                = rp_key_reg;
    assign reply_valid_out           = reply_valid_reg;
    assign reply_response_out        = reply_resp_reg;
    assign reply_fixed_challenge_out = reply_fc_reg;
    assign reply_seed_out            = reply_seed_reg;
    assign busy_out                  = busy_reg;
    assign stored_valid_out          = stored_valid_reg;

    // helper: previous challenge handed to the response unit
    logic [CHAL_W-1:0] prev_fc_reg;
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            prev_fc_reg <= HALF_RST;
        end else if (rp_start_reg) begin
            prev_fc_reg <= rp_fc_reg;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    seed_half_order_a: assert property (
        kd_start_out |-> (kd_seed_out[SEED_W-1:HALF_W] == $past(fresh_word[IDX_HIGH]))
                         && (kd_seed_out[HALF_W-1:0] == $past(fresh_word[IDX_LOW])))
        else $error("seed halves out of order");

    seed_distinct_a: assert property (
        kd_start_out |-> kd_seed_out != $past(portable_seed_in))
        else $error("derivation seed equals portable-side seed");

    derive_single_a: assert property (
        kd_start_out |=> !kd_start_out && state_reg == ST_DERIVE)
        else $error("derivation started twice");

    visited_pair_a: assert property (
        (state_reg == ST_IDLE && req_valid_in && assigned_valid_in)
        |=> seed_used_reg == $past(assigned_seed_in) && key_used_reg == $past(assigned_key_in)
            && state_reg == ST_CHAL)
        else $error("assigned pair not used");

    reuse_select_a: assert property (
        (state_reg == ST_IDLE && req_valid_in && !assigned_valid_in && !reuse_allowed_in)
        |=> state_reg == ST_SEED)
        else $error("forced derivation skipped");

    reuse_stored_a: assert property (
        (state_reg == ST_IDLE && req_valid_in && !assigned_valid_in
         && reuse_allowed_in && stored_valid_reg)
        |=> key_used_reg == $past(stored_key_reg) && seed_used_reg == $past(stored_seed_reg))
        else $error("stored pair not reused");

    resp_inputs_a: assert property (
        rp_start_out |-> rp_key_out == key_used_reg && rp_portable_challenge_out == pchal_reg)
        else $error("response inputs wrong");

    fresh_chal_a: assert property (
        rp_start_out |-> rp_fixed_challenge_out != prev_fc_reg ##1 !rp_start_out)
        else $error("fixed challenge repeated");

    reply_fields_a: assert property (
        reply_valid_out |-> reply_fixed_challenge_out == rp_fixed_challenge_out
                            && reply_seed_out == seed_used_reg
                            && reply_response_out == $past(rp_response_in))
        else $error("reply fields wrong");

    check_compare_a: assert property (
        check_done_out |-> check_pass_out == ($past(check_response_in) == $past(resp_store_reg)))
        else $error("compare outcome wrong");
endmodule
`default_nettype wire

//--- common/cra_pkg.sv
package cra_pkg;

    // widths of the exchanged values
    localparam int HALF_W = 64;
    localparam int SEED_W = 128;
    localparam int KEY_W  = 128;
    localparam int CHAL_W = 64;
    localparam int RESP_W = 32;

    // slots of the fresh value sources
    localparam int NUM_FRESH = 3;
    localparam int IDX_LOW   = 0;
    localparam int IDX_HIGH  = 1;
    localparam int IDX_CHAL  = 2;

    // reset values
    localparam logic [HALF_W-1:0] HALF_RST = 64'h0000_0000_0000_0000;
    localparam logic [SEED_W-1:0] SEED_RST = 128'h0000_0000_0000_0000_0000_0000_0000_0000;
    localparam logic [KEY_W-1:0]  KEY_RST  = 128'h0000_0000_0000_0000_0000_0000_0000_0000;
    localparam logic [RESP_W-1:0] RESP_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEED,
        ST_DERIVE,
        ST_CHAL,
        ST_RESP
    } cra_state_t;

endpackage

//--- verilog/cra_fresh_word.sv
`timescale 1ns/10ps
`default_nettype none
module cra_fresh_word
    import cra_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    // random source
    input  wire logic [HALF_W-1:0] rand_word_in,
    input  wire logic              rand_valid_in,
    // consumer
    input  wire logic              take_in,
    output logic      [HALF_W-1:0] word_out,
    output logic                   ready_out
);
    logic [HALF_W-1:0] word_reg;
    logic [HALF_W-1:0] word_next;
    logic [HALF_W-1:0] last_reg;
    logic [HALF_W-1:0] last_next;
    logic              have_reg;
    logic              have_next;

    // a word is handed out once, then dropped; a repeat of the last one is refused
    always_comb begin
        word_next = word_reg;
        last_next = last_reg;
        have_next = have_reg;
        if (take_in && have_reg) begin
            have_next = 1'b0;
            last_next = word_reg;
        end
        if (rand_valid_in && !have_next && (rand_word_in != last_next)) begin
            word_next = rand_word_in;
            have_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            word_reg <= HALF_RST;
            last_reg <= HALF_RST;
            have_reg <= 1'b0;
        end else begin
            word_reg <= word_next;
            last_reg <= last_next;
            have_reg <= have_next;
        end
    end

    assign word_out  = word_reg;
    assign ready_out = have_reg;
endmodule
`default_nettype wire

//--- verilog/cra_resp_cmp.sv
`timescale 1ns/10ps
`default_nettype none
module cra_resp_cmp
    import cra_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    // compare request
    input  wire logic              check_valid_in,
    input  wire logic [RESP_W-1:0] expected_in,
    input  wire logic [RESP_W-1:0] received_in,
    // outcome
    output logic                   done_out,
    output logic                   pass_out
);
    logic done_reg;
    logic done_next;
    logic pass_reg;
    logic pass_next;

    always_comb begin
        done_next = check_valid_in;
        pass_next = pass_reg;
        if (check_valid_in) begin
            pass_next = (expected_in == received_in);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            done_reg <= 1'b0;
            pass_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
            pass_reg <= pass_next;
        end
    end

    assign done_out = done_reg;
    assign pass_out = pass_reg;
endmodule
`default_nettype wire

//--- verification/cra_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module cra_far_model
    import cra_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    // answer delay
    input  wire logic [3:0]        delay_in,
    // key derivation unit
    input  wire logic              kd_start_in,
    input  wire logic [SEED_W-1:0] kd_seed_in,
    output logic                   kd_done_out,
    output logic      [KEY_W-1:0]  kd_key_out,
    // response unit
    input  wire logic              rp_start_in,
    input  wire logic [CHAL_W-1:0] rp_fixed_in,
    input  wire logic [CHAL_W-1:0] rp_port_in,
    input  wire logic [KEY_W-1:0]  rp_key_in,
    output logic                   rp_done_out,
    output logic      [RESP_W-1:0] rp_resp_out
);
    logic       kd_busy_reg;
    logic       rp_busy_reg;
    logic [3:0] kd_cnt_reg;
    logic [3:0] rp_cnt_reg;
    // data toggles between answers so a stale value never passes for a fresh one
    always_ff @(posedge ref_clk_in) begin
        kd_done_out <= 1'b0;
        rp_done_out <= 1'b0;
        kd_key_out  <= ~kd_key_out;
        rp_resp_out <= ~rp_resp_out;
        if (!rst_n_in) begin
            kd_busy_reg <= 1'b0;
            rp_busy_reg <= 1'b0;
            kd_key_out  <= KEY_RST;
            rp_resp_out <= RESP_RST;
        end else begin
            if (kd_start_in) begin
                kd_busy_reg <= 1'b1;
                kd_cnt_reg  <= delay_in;
            end else if (kd_busy_reg) begin
                kd_cnt_reg <= kd_cnt_reg - 4'h1;
                if (kd_cnt_reg == 4'h0) begin
                    kd_busy_reg <= 1'b0;
                    kd_done_out <= 1'b1;
                    kd_key_out  <= ~kd_seed_in;
                end
            end
            if (rp_start_in) begin
                rp_busy_reg <= 1'b1;
                rp_cnt_reg  <= delay_in;
            end else if (rp_busy_reg) begin
                rp_cnt_reg <= rp_cnt_reg - 4'h1;
                if (rp_cnt_reg == 4'h0) begin
                    rp_busy_reg <= 1'b0;
                    rp_done_out <= 1'b1;
                    rp_resp_out <= rp_key_in[31:0] ^ rp_fixed_in[31:0] ^ rp_port_in[63:32];
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/challenge_response_auth_type2_tb.sv
`timescale 1ns/10ps
`default_nettype none
module challenge_response_auth_type2_tb;
    import cra_pkg::*;
    logic              ref_clk_in = 1'b0;
    logic              rst_n_in = 1'b0;
    logic              req_v = 0, reuse = 0, asg_v = 0, lo_v = 0, hi_v = 0, ch_v = 0, chk_v = 0;
    logic              have_st = 0;
    logic [CHAL_W-1:0] pch = '0, lo_w = '0, hi_w = '0, ch_w = '0;
    logic [SEED_W-1:0] asg_seed = '0, port_seed = '0, st_seed = '0;
    logic [KEY_W-1:0]  asg_key = '0;
    logic [RESP_W-1:0] chk_r = '0;
    logic [3:0]        dly = '0;
    logic [63:0]       rnd = 64'h0000_0000_0000_002B;
    wire               kd_st, kd_dn, rp_st, rp_dn, rep_v, c_done, c_pass, busy, stv;
    wire  [SEED_W-1:0] kd_seed, rep_seed;
    wire  [KEY_W-1:0]  kd_key, rp_key;
    wire  [CHAL_W-1:0] rp_fc, rp_pc, rep_fc;
    wire  [RESP_W-1:0] rp_resp, rep_resp;
    int                num_errors = 0, checked = 0, kd_cnt = 0, cyc = 0, k;

    always #20 ref_clk_in = ~ref_clk_in;

    cra_fixed_auth u_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_v),
        .portable_challenge_in(pch), .reuse_allowed_in(reuse), .assigned_valid_in(asg_v),
        .assigned_seed_in(asg_seed), .assigned_key_in(asg_key), .portable_seed_in(port_seed),
        .seed_low_rand_in(lo_w), .seed_low_rand_valid_in(lo_v), .seed_high_rand_in(hi_w),
        .seed_high_rand_valid_in(hi_v), .chal_rand_in(ch_w), .chal_rand_valid_in(ch_v),
        .kd_start_out(kd_st), .kd_seed_out(kd_seed), .kd_done_in(kd_dn), .kd_key_in(kd_key),
        .rp_start_out(rp_st), .rp_fixed_challenge_out(rp_fc), .rp_portable_challenge_out(rp_pc),
        .rp_key_out(rp_key), .rp_done_in(rp_dn), .rp_response_in(rp_resp),
        .reply_valid_out(rep_v), .reply_response_out(rep_resp), .reply_fixed_challenge_out(rep_fc),
        .reply_seed_out(rep_seed), .check_valid_in(chk_v), .check_response_in(chk_r),
        .check_done_out(c_done), .check_pass_out(c_pass), .busy_out(busy), .stored_valid_out(stv));

    cra_far_model u_far (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .delay_in(dly),
        .kd_start_in(kd_st), .kd_seed_in(kd_seed), .kd_done_out(kd_dn), .kd_key_out(kd_key),
        .rp_start_in(rp_st), .rp_fixed_in(rp_fc), .rp_port_in(rp_pc), .rp_key_in(rp_key),
        .rp_done_out(rp_dn), .rp_resp_out(rp_resp));

    function automatic logic [63:0] nx(input logic [63:0] x);
        return {x[62:0], x[63] ^ x[62] ^ x[60] ^ x[59]};
    endfunction

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // one request from the terminal side, then a good and a one-bit-off echo
    task automatic auth(input logic nw);
        logic         d;
        logic [127:0] es, ek;
        logic [31:0]  er;
        int           k0;
        @(posedge ref_clk_in);
        d = !asg_v && (!reuse || !have_st);
        k0 = kd_cnt;
        rnd = nx(rnd);
        ch_w <= rnd;
        ch_v <= 1'b1;
        rnd = nx(rnd);
        pch <= rnd;
        dly <= rnd[3:0];
        req_v <= 1'b1;
        if (nw) begin
            rnd = nx(rnd);
            lo_w <= rnd;
            rnd = nx(rnd);
            hi_w <= rnd;
            lo_v <= 1'b1;
            hi_v <= 1'b1;
        end
        @(posedge ref_clk_in);
        req_v <= 1'b0;
        for (int n = 0; n < 400 && rep_v !== 1'b1; n++) @(negedge ref_clk_in);
        chk(rep_v, 1'b1);
        chk(busy, 1'b0);
        es = asg_v ? asg_seed : (d ? {hi_w, lo_w} : st_seed);
        ek = asg_v ? asg_key : ~es;
        er = ek[31:0] ^ ch_w[31:0] ^ pch[63:32];
        chk(rep_seed, es);
        chk(rp_key, ek);
        chk(rep_fc, ch_w);
        chk(rp_pc, pch);
        chk(rep_resp, er);
        chk(kd_cnt, k0 + d);
        chk(kd_seed == port_seed, 1'b0);
        chk(stv, have_st | d);
        if (d) begin
            st_seed = es;
            have_st = 1'b1;
        end
        @(posedge ref_clk_in);
        lo_v <= 1'b0;
        hi_v <= 1'b0;
        ch_v <= 1'b0;
        chk_v <= 1'b1;
        chk_r <= er;
        @(posedge ref_clk_in);
        chk_r <= er ^ (32'h0000_0001 << rnd[4:0]);
        @(negedge ref_clk_in);
        chk({c_done, c_pass}, 2'b11);
        @(posedge ref_clk_in);
        chk_v <= 1'b0;
        @(negedge ref_clk_in);
        chk({c_done, c_pass}, 2'b10);
        @(posedge ref_clk_in);
    endtask

    always @(posedge ref_clk_in) begin
        cyc++;
        if (kd_st === 1'b1)
            kd_cnt++;
        if (cyc == 5000) begin
            num_errors++;
            end_sim();
        end
    end

    initial begin
        repeat (3) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        auth(1'b1);
        $display("test derive done");
        reuse <= 1'b1;
        auth(1'b0);
        $display("test reuse done");
        // stale halves offered first, then halves equal to the portable seed
        reuse <= 1'b0;
        lo_v <= 1'b1;
        hi_v <= 1'b1;
        k = kd_cnt;
        fork
            auth(1'b0);
            begin
                repeat (20) @(negedge ref_clk_in);
                chk(kd_cnt, k);
                @(posedge ref_clk_in);
                rnd = nx(rnd);
                lo_w <= rnd;
                port_seed[63:0] <= rnd;
                rnd = nx(rnd);
                hi_w <= rnd;
                port_seed[127:64] <= rnd;
                repeat (20) @(negedge ref_clk_in);
                chk(kd_cnt, k);
                @(posedge ref_clk_in);
                rnd = nx(rnd);
                lo_w <= rnd;
                rnd = nx(rnd);
                hi_w <= rnd;
            end
        join
        $display("test refusal done");
        asg_v <= 1'b1;
        reuse <= 1'b1;
        rnd = nx(rnd);
        asg_seed <= {rnd, ~rnd};
        asg_key <= {~rnd, rnd ^ 64'h0000_0000_FFFF_0000};
        auth(1'b0);
        $display("test assigned done");
        asg_v <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rnd = nx(rnd);
            reuse <= rnd[0];
            port_seed <= {rnd, ~rnd};
            auth(!(rnd[0] && have_st));
        end
        $display("test random done");
        end_sim();
    end
endmodule
`default_nettype wire
